// [common/ufw_map.svh]
// How it works
// - two watchdogs, own count register each
// - count is 14 bits, top two reserved
// - counter decrements on each 12 MHz tick
// - count resets to 0x2ee0
// - expiry sets timeout flag, enable raises interrupt
// - timeout enable and flag in interrupt registers
// - otg control serves first port, overrides pulls
// - bit 13 drives vbus pull-up
// - bit 12 powers down otg receiver
// - bit 11 drives vbus charge pump
// - bit 10 drives vbus discharge pull-down
// - bits 9, 8 drive data-line pull-ups
// - bits 7, 6 drive data-line pull-downs
// - status bit 2 shows vbus level
// - status bit 1 shows id pin
// - status bit 0 shows vbus valid
// - 3-bit timeout count, cleared by marker, tracked only with timeout enable on
// - frame register bit 15 flags timeout only while timeout enable is on
// - id interrupt on both edges, port one
`ifndef UFW_MAP_SVH
`define UFW_MAP_SVH

// ****************************************
// register byte addresses
// ****************************************
`define UFW_OFS_WDOG1 16'hc094
`define UFW_OFS_OTG 16'hc098
`define UFW_OFS_WDOG2 16'hc0b4
`define UFW_OFS_IEN1 16'hc080
`define UFW_OFS_STAT1 16'hc084
`define UFW_OFS_FRM1 16'hc088
`define UFW_OFS_IEN2 16'hc0a0
`define UFW_OFS_STAT2 16'hc0a4
`define UFW_OFS_FRM2 16'hc0a8

// ****************************************
// reset values and timing
// ****************************************
`define UFW_WDOG_RESET 14'h2ee0
`define UFW_CLK_MHZ 40
`define UFW_TICK_MHZ 12

// ****************************************
// field positions
// ****************************************
`define UFW_OTG_VBUS_PU 13
`define UFW_OTG_RX_PD 12
`define UFW_OTG_CPUMP 11
`define UFW_OTG_VBUS_DIS 10
`define UFW_OTG_DP_PU 9
`define UFW_OTG_DM_PU 8
`define UFW_OTG_DP_PD 7
`define UFW_OTG_DM_PD 6
`define UFW_OTG_VBUS_LVL 2
`define UFW_OTG_ID 1
`define UFW_OTG_VVALID 0
`define UFW_INT_TO 10
`define UFW_INT_ID 14
`define UFW_FRM_FLAG 15
`define UFW_FRM_TOCNT 12

`endif

// [common/ufw_pkg.sv]
package ufw_pkg;
	typedef logic [13:0] ufw_cnt_t;
	typedef logic [10:0] ufw_frame_t;
	typedef enum logic [1:0] {
		UFW_IDLE = 2'b00,
		UFW_REPLY = 2'b01
	} ufw_apb_st_t;
endpackage

// [dv/ufw_usb_peer.sv]
`timescale 1ns/100ps
module ufw_usb_peer #(
	parameter int SETTLE = 200
) (
	// clock and charge pump from the block
	input wire logic clock,
	input wire logic chargePump,
	// marker and pins to the block
	output logic sofEop,
	output ufw_pkg::ufw_frame_t frameNum,
	output logic vbusPin,
	output logic idPin,
	output logic vbusValidIn
);
	import ufw_pkg::*;
	int settle = 0;
	initial begin
		sofEop = 1'b0;
		frameNum = 11'h000;
		idPin = 1'b0;
		vbusPin = 1'b0;
		vbusValidIn = 1'b0;
	end
	// vbus needs time to climb past the valid level
	always @(posedge clock) begin
		vbusPin <= chargePump;
		settle <= chargePump ? settle + 1 : 0;
		vbusValidIn <= chargePump && settle >= SETTLE;
	end
	task automatic send_marker(input ufw_frame_t f);
		@(posedge clock);
		sofEop <= 1'b1;
		frameNum <= f;
		@(posedge clock);
		sofEop <= 1'b0;
		// number is only meaningful with the marker
		frameNum <= ~f;
	endtask
	task automatic set_id(input logic v);
		@(posedge clock);
		idPin <= v;
	endtask
endmodule

// [dv/usb_frame_watchdog_otg_ctrl_tb_top.sv]
`timescale 1ns/100ps
`include "ufw_map.svh"
module usb_frame_watchdog_otg_ctrl_tb_top;
	import ufw_pkg::*;
	// ******************
	// signals
	// ******************
	logic clock = 1'b0;
	logic rst = 1'b1;
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic [15:0] paddr = 16'h0000;
	logic [31:0] pwdata = 32'h00000000;
	logic [31:0] prdata;
	logic pready, pslverr, sofEop1, vbusPin, idPin, vbusValidIn;
	logic irqDev1, irqDev2, vbusPullUp, rxPowerDown, chargePump;
	logic vbusDischarge, dpPullUp, dmPullUp, dpPullDown, dmPullDown;
	ufw_frame_t frameNum1;
	logic sofEop2 = 1'b0;
	ufw_frame_t frameNum2 = 11'h000;
	logic [7:0] pulls;
	logic [31:0] r;
	logic e;
	int errors = 0;
	int nCompared = 0;
	int cycles = 0;
	always #12.5 clock = ~clock;
	assign pulls = {vbusPullUp, rxPowerDown, chargePump, vbusDischarge,
		dpPullUp, dmPullUp, dpPullDown, dmPullDown};
	ufw_top ufw_top_inst (.clock(clock), .rst(rst), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr),
		.pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .sofEop1(sofEop1), .frameNum1(frameNum1),
		.sofEop2(sofEop2), .frameNum2(frameNum2), .vbusPin(vbusPin),
		.idPin(idPin), .vbusValidIn(vbusValidIn), .irqDev1(irqDev1),
		.irqDev2(irqDev2), .vbusPullUp(vbusPullUp),
		.rxPowerDown(rxPowerDown), .chargePump(chargePump),
		.vbusDischarge(vbusDischarge), .dpPullUp(dpPullUp),
		.dmPullUp(dmPullUp), .dpPullDown(dpPullDown),
		.dmPullDown(dmPullDown));
	ufw_usb_peer ufw_usb_peer_inst (.clock(clock),
		.chargePump(chargePump), .sofEop(sofEop1),
		.frameNum(frameNum1), .vbusPin(vbusPin), .idPin(idPin),
		.vbusValidIn(vbusValidIn));
	// ******************
	// tasks
	// ******************
	task automatic stop_test();
		$display("compared %0d, mismatches %0d", nCompared, errors);
		if (errors == 0 && nCompared > 0) begin
			$display("Run complete: PASS");
		end else begin
			$display("Run complete: FAIL");
		end
		$finish;
	endtask
	task automatic chk(input string what, input logic [31:0] seen,
		input logic [31:0] exp);
		nCompared++;
		if (seen !== exp) begin
			errors++;
			$display("[ERR] %s expected %h seen %h", what, exp, seen);
		end
	endtask
	function automatic logic [31:0] inr(input logic [31:0] v,
		input logic [31:0] lo, input logic [31:0] hi);
		return {31'h0, (v >= lo && v <= hi)};
	endfunction
	task automatic cyc(input int n);
		repeat (n) @(posedge clock);
	endtask
	// one idle edge before each setup keeps drives single per step
	task automatic apb(input logic [15:0] a, input logic w,
		input logic [31:0] d);
		@(posedge clock);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clock);
		penable <= 1'b1;
		// only the bench timeout ends a wait that never answers
		do begin
			@(posedge clock);
		end while (pready !== 1'b1);
		r = prdata;
		e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task automatic wr(input logic [15:0] a, input logic [31:0] d);
		apb(a, 1'b1, d);
	endtask
	task automatic rd(input logic [15:0] a);
		apb(a, 1'b0, 32'h00000000);
	endtask
	// ******************
	// tests
	// ******************
	always @(posedge clock) begin
		cycles <= cycles + 1;
		if (cycles == 10000) begin
			errors++;
			stop_test();
		end
	end
	initial begin
		cyc(20);
		rst <= 1'b0;
		rd(`UFW_OFS_WDOG1);
		chk("wdog1 reset", inr(r, 32'h2edc, 32'h2ee0), 32'h1);
		rd(`UFW_OFS_WDOG2);
		chk("wdog2 reset", inr(r, 32'h2edc, 32'h2ee0), 32'h1);
		rd(`UFW_OFS_OTG);
		chk("otg reset", r & 32'h3fc0, 32'h0);
		chk("pulls reset", {24'h0, pulls}, 32'h0);
		$display("test reset done");
		// about 1005 clocks at 3 ticks in 10
		wr(`UFW_OFS_WDOG1, 32'h1000);
		cyc(1000);
		rd(`UFW_OFS_WDOG1);
		chk("wdog rate", inr(r, 32'h0ece, 32'h0ed6), 32'h1);
		$display("test rate done");
		wr(`UFW_OFS_IEN1, 32'h0400);
		wr(`UFW_OFS_WDOG1, 32'h0014);
		cyc(800);
		wr(`UFW_OFS_WDOG1, 32'h3fff);
		rd(`UFW_OFS_FRM1);
		chk("frm flag cnt", r & 32'hf000, 32'hf000);
		rd(`UFW_OFS_STAT1);
		chk("to flag1", r & 32'h0400, 32'h0400);
		chk("irq1 on", {31'h0, irqDev1}, 32'h1);
		wr(`UFW_OFS_STAT1, 32'h0400);
		cyc(3);
		chk("irq1 off", {31'h0, irqDev1}, 32'h0);
		ufw_usb_peer_inst.send_marker(11'h2a5);
		cyc(3);
		rd(`UFW_OFS_FRM1);
		chk("frm marker", r, 32'h000002a5);
		rd(`UFW_OFS_WDOG1);
		chk("reload", inr(r, 32'h3ff0, 32'h3fff), 32'h1);
		wr(`UFW_OFS_WDOG2, 32'h0014);
		cyc(200);
		rd(`UFW_OFS_STAT2);
		chk("to flag2", r & 32'h0400, 32'h0400);
		chk("irq2 gated", {31'h0, irqDev2}, 32'h0);
		rd(`UFW_OFS_FRM2);
		chk("frm2 frozen", r & 32'hf000, 32'h0);
		// second port: enable, let it expire, then a marker clears
		wr(`UFW_OFS_IEN2, 32'h0400);
		cyc(200);
		chk("irq2 on", {31'h0, irqDev2}, 32'h1);
		rd(`UFW_OFS_FRM2);
		chk("frm2 flag", r & 32'h8000, 32'h8000);
		@(posedge clock);
		sofEop2 <= 1'b1;
		frameNum2 <= 11'h155;
		@(posedge clock);
		sofEop2 <= 1'b0;
		cyc(2);
		rd(`UFW_OFS_FRM2);
		chk("frm2 marker", r, 32'h00000155);
		$display("test expiry done");
		for (int b = 6; b < 14; b++) begin
			wr(`UFW_OFS_OTG, 32'h1 << b);
			rd(`UFW_OFS_OTG);
			chk("otg rb", r & 32'h3fc0, 32'h1 << b);
			chk("otg pins", {24'h0, pulls}, 32'h1 << (b - 6));
		end
		$display("test controls done");
		ufw_usb_peer_inst.set_id(1'b1);
		wr(`UFW_OFS_OTG, 32'h0800);
		// valid level needs 5 us, 200 clocks
		cyc(400);
		rd(`UFW_OFS_OTG);
		chk("status on", r, 32'h00000807);
		wr(`UFW_OFS_OTG, 32'h0000);
		cyc(6);
		rd(`UFW_OFS_OTG);
		chk("status off", r, 32'h00000002);
		wr(`UFW_OFS_IEN1, 32'h4000);
		for (int k = 0; k < 2; k++) begin
			ufw_usb_peer_inst.set_id(k[0]);
			cyc(6);
			rd(`UFW_OFS_STAT1);
			chk("id flag", r & 32'h4000, 32'h4000);
			chk("id irq", {31'h0, irqDev1}, 32'h1);
			wr(`UFW_OFS_STAT1, 32'h4000);
		end
		$display("test otg status done");
		apb(16'hc090, 1'b0, 32'h0);
		chk("unmapped rd", {r[30:0], e}, 32'h1);
		apb(16'hc090, 1'b1, 32'h1234);
		chk("unmapped wr", {31'h0, e}, 32'h1);
		$display("test unmapped done");
		stop_test();
	end
endmodule

// [rtl/ufw_frame_watchdog.sv]
`timescale 1ns/100ps
`include "ufw_map.svh"
module ufw_frame_watchdog (
	// clock and reset
	input wire logic clock,
	input wire logic rst,
	// timebase and frame marker
	input wire logic tick,
	input wire logic marker,
	// software load
	input wire logic load,
	input wire ufw_pkg::ufw_cnt_t loadVal,
	// state
	output ufw_pkg::ufw_cnt_t count,
	output logic expire
);
	import ufw_pkg::*;

	ufw_cnt_t interval;

	always_ff @(posedge clock) begin
		if (rst) begin
			interval <= `UFW_WDOG_RESET;
			count <= `UFW_WDOG_RESET;
			expire <= 1'b0;
		end else begin
			expire <= 1'b0;
			if (load) begin
				interval <= loadVal;
				count <= loadVal;
			end else if (marker) begin
				count <= interval;
			end else if (tick) begin
				if (count == 14'h0000) begin
					expire <= 1'b1;
					count <= interval;
				end else begin
					count <= count - 14'h0001;
				end
			end
		end
	end

	count_reset_a: assert property (@(posedge clock)
		$past(rst) |-> count == `UFW_WDOG_RESET)
		else $error("watchdog count not at reset value");

	count_step_a: assert property (@(posedge clock) disable iff (rst)
		tick && !marker && !load && count != 14'h0000
		|=> count == $past(count) - 14'h0001)
		else $error("watchdog count did not step down");

	marker_reload_a: assert property (@(posedge clock) disable iff (rst)
		marker && !load |=> count == $past(interval))
		else $error("watchdog not reloaded on marker");
endmodule

// [rtl/ufw_sync.sv]
`timescale 1ns/100ps
module ufw_sync #(
	parameter int WIDTH = 3
) (
	// clock and reset
	input wire logic clock,
	input wire logic rst,
	// pins in, filtered levels out
	input wire logic [WIDTH-1:0] pinIn,
	output logic [WIDTH-1:0] level
);
	logic [WIDTH-1:0] s1;
	logic [WIDTH-1:0] s2;
	logic [WIDTH-1:0] s3;
	logic [WIDTH-1:0] agree;

	assign agree = ~(s2 ^ s3);

	always_ff @(posedge clock) begin
		if (rst) begin
			s1 <= '0;
			s2 <= '0;
			s3 <= '0;
			level <= '0;
		end else begin
			s1 <= pinIn;
			s2 <= s1;
			s3 <= s2;
			// a change counts only once two stages agree
			level <= (agree & s3) | (~agree & level);
		end
	end
endmodule

// [rtl/ufw_top.sv]
// Design decision made here: the APB interface to the registers.
`timescale 1ns/100ps
`include "ufw_map.svh"
module ufw_top (
	// clock and reset
	input wire logic clock,
	input wire logic rst,
	// apb slave
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [15:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// usb core, device one
	input wire logic sofEop1,
	input wire ufw_pkg::ufw_frame_t frameNum1,
	// usb core, device two
	input wire logic sofEop2,
	input wire ufw_pkg::ufw_frame_t frameNum2,
	// otg pins in
	input wire logic vbusPin,
	input wire logic idPin,
	input wire logic vbusValidIn,
	// interrupt lines
	output logic irqDev1,
	output logic irqDev2,
	// otg analog controls
	output logic vbusPullUp,
	output logic rxPowerDown,
	output logic chargePump,
	output logic vbusDischarge,
	output logic dpPullUp,
	output logic dmPullUp,
	output logic dpPullDown,
	output logic dmPullDown
);
	import ufw_pkg::*;

	// ****************************************
	// helpers
	// ****************************************
	function automatic logic [2:0] ufw_sat_inc(input logic [2:0] v);
		return (v == 3'h7) ? v : v + 3'h1;
	endfunction

	function automatic logic [15:0] ufw_frm_word(
		input logic flag,
		input logic [2:0] cnt,
		input ufw_frame_t frm
	);
		logic [15:0] w;
		w = 16'h0000;
		w[`UFW_FRM_FLAG] = flag;
		w[`UFW_FRM_TOCNT +: 3] = cnt;
		w[10:0] = frm;
		return w;
	endfunction

	// ****************************************
	// 12 mhz timebase
	// ****************************************
	// fractional accumulator: no 12 mhz clock, so ticks
	// jitter by one system cycle but average exactly
	localparam logic [5:0] TICK_STEP = 6'(`UFW_TICK_MHZ);
	localparam logic [5:0] TICK_MOD = 6'(`UFW_CLK_MHZ);

	logic [5:0] tickAcc;
	logic [5:0] next_tickAcc;
	logic tick;

	always_comb begin
		next_tickAcc = tickAcc + TICK_STEP;
		if (next_tickAcc >= TICK_MOD) begin
			next_tickAcc = next_tickAcc - TICK_MOD;
		end
	end

	always_ff @(posedge clock) begin
		if (rst) begin
			tickAcc <= 6'h00;
			tick <= 1'b0;
		end else begin
			tickAcc <= next_tickAcc;
			tick <= (tickAcc + TICK_STEP) >= TICK_MOD;
		end
	end

	// ****************************************
	// apb handshake
	// ****************************************
	// one wait state: pready is a flop so the
	// answer never depends on a combinational path
	ufw_apb_st_t apbState;
	logic access;
	logic done;
	logic wr;
	logic hit;
	logic [15:0] next_rdata;

	assign access = psel && penable;
	assign done = access && pready;
	assign wr = done && pwrite;

	always_ff @(posedge clock) begin
		if (rst) begin
			apbState <= UFW_IDLE;
			pready <= 1'b0;
			pslverr <= 1'b0;
			prdata <= 32'h0000_0000;
		end else begin
			case (apbState)
				UFW_IDLE: begin
					if (access) begin
						apbState <= UFW_REPLY;
						pready <= 1'b1;
						pslverr <= !hit;
						prdata <= {16'h0000, next_rdata};
					end
				end
				UFW_REPLY: begin
					apbState <= UFW_IDLE;
					pready <= 1'b0;
					pslverr <= 1'b0;
				end
				default: begin
					apbState <= UFW_IDLE;
					pready <= 1'b0;
					pslverr <= 1'b0;
				end
			endcase
		end
	end

	// ****************************************
	// status pin synchronisers
	// ****************************************
	logic [2:0] pinLevel;
	logic vbusLevel;
	logic idLevel;
	logic vbusValid;

	ufw_sync #(
		.WIDTH(3)
	) pinSync (
		.clock(clock),
		.rst(rst),
		.pinIn({vbusPin, idPin, vbusValidIn}),
		.level(pinLevel)
	);

	assign vbusLevel = pinLevel[2];
	assign idLevel = pinLevel[1];
	assign vbusValid = pinLevel[0];

	// ****************************************
	// frame watchdogs
	// ****************************************
	logic [1:0] marker;
	logic [1:0] wdLoad;
	logic [1:0] expire;
	ufw_cnt_t wdCount [2];
	ufw_frame_t frameIn [2];

	assign marker = {sofEop2, sofEop1};
	assign frameIn[0] = frameNum1;
	assign frameIn[1] = frameNum2;
	assign wdLoad[0] = wr && paddr == `UFW_OFS_WDOG1;
	assign wdLoad[1] = wr && paddr == `UFW_OFS_WDOG2;

	for (genvar d = 0; d < 2; d++) begin : g_wd
		ufw_frame_watchdog wdog (
			.clock(clock),
			.rst(rst),
			.tick(tick),
			.marker(marker[d]),
			.load(wdLoad[d]),
			.loadVal(pwdata[13:0]),
			.count(wdCount[d]),
			.expire(expire[d])
		);
	end

	// ****************************************
	// interrupt enable and status
	// ****************************************
	logic [1:0] toEn;
	logic idEn;
	logic [1:0] toFlag;
	logic idFlag;
	logic idPrev;
	logic idEdge;
	logic [1:0] ienWr;
	logic [1:0] statWr;

	assign ienWr[0] = wr && paddr == `UFW_OFS_IEN1;
	assign ienWr[1] = wr && paddr == `UFW_OFS_IEN2;
	assign statWr[0] = wr && paddr == `UFW_OFS_STAT1;
	assign statWr[1] = wr && paddr == `UFW_OFS_STAT2;
	assign idEdge = idLevel ^ idPrev;

	always_ff @(posedge clock) begin
		if (rst) begin
			toEn <= 2'h0;
			idEn <= 1'b0;
		end else begin
			for (int d = 0; d < 2; d++) begin
				if (ienWr[d]) begin
					toEn[d] <= pwdata[`UFW_INT_TO];
				end
			end
			// id interrupt exists on the first port only
			if (ienWr[0]) begin
				idEn <= pwdata[`UFW_INT_ID];
			end
		end
	end

	// flags clear on writing one; a new event wins
	always_ff @(posedge clock) begin
		if (rst) begin
			toFlag <= 2'h0;
			idFlag <= 1'b0;
			idPrev <= 1'b0;
		end else begin
			idPrev <= idLevel;
			for (int d = 0; d < 2; d++) begin
				if (expire[d]) begin
					toFlag[d] <= 1'b1;
				end else if (statWr[d] && pwdata[`UFW_INT_TO]) begin
					toFlag[d] <= 1'b0;
				end
			end
			if (idEdge && idEn) begin
				idFlag <= 1'b1;
			end else if (statWr[0] && pwdata[`UFW_INT_ID]) begin
				idFlag <= 1'b0;
			end
		end
	end

	always_ff @(posedge clock) begin
		if (rst) begin
			irqDev1 <= 1'b0;
			irqDev2 <= 1'b0;
		end else begin
			irqDev1 <= (toFlag[0] && toEn[0]) || idFlag;
			irqDev2 <= toFlag[1] && toEn[1];
		end
	end

	// ****************************************
	// frame number registers
	// ****************************************
	logic [1:0] frmFlag;
	logic [2:0] toCnt [2];
	ufw_frame_t frameLast [2];

	always_ff @(posedge clock) begin
		if (rst) begin
			frmFlag <= 2'h0;
			for (int d = 0; d < 2; d++) begin
				toCnt[d] <= 3'h0;
				frameLast[d] <= 11'h000;
			end
		end else begin
			for (int d = 0; d < 2; d++) begin
				if (marker[d]) begin
					frameLast[d] <= frameIn[d];
				end
				// only tracked while the timeout enable is on
				if (toEn[d]) begin
					if (marker[d]) begin
						toCnt[d] <= 3'h0;
						frmFlag[d] <= 1'b0;
					end else if (expire[d]) begin
						toCnt[d] <= ufw_sat_inc(toCnt[d]);
						frmFlag[d] <= 1'b1;
					end
				end
			end
		end
	end

	// ****************************************
	// otg port control
	// ****************************************
	// these pins belong to the first port and take
	// precedence over the general port pull settings
	always_ff @(posedge clock) begin
		if (rst) begin
			vbusPullUp <= 1'b0;
			rxPowerDown <= 1'b0;
			chargePump <= 1'b0;
			vbusDischarge <= 1'b0;
			dpPullUp <= 1'b0;
			dmPullUp <= 1'b0;
			dpPullDown <= 1'b0;
			dmPullDown <= 1'b0;
		end else if (wr && paddr == `UFW_OFS_OTG) begin
			vbusPullUp <= pwdata[`UFW_OTG_VBUS_PU];
			rxPowerDown <= pwdata[`UFW_OTG_RX_PD];
			chargePump <= pwdata[`UFW_OTG_CPUMP];
			vbusDischarge <= pwdata[`UFW_OTG_VBUS_DIS];
			dpPullUp <= pwdata[`UFW_OTG_DP_PU];
			dmPullUp <= pwdata[`UFW_OTG_DM_PU];
			dpPullDown <= pwdata[`UFW_OTG_DP_PD];
			dmPullDown <= pwdata[`UFW_OTG_DM_PD];
		end
	end

	// ****************************************
	// read multiplexer
	// ****************************************
	always_comb begin
		next_rdata = 16'h0000;
		hit = 1'b1;
		case (paddr)
			`UFW_OFS_WDOG1: next_rdata[13:0] = wdCount[0];
			`UFW_OFS_WDOG2: next_rdata[13:0] = wdCount[1];
			`UFW_OFS_OTG: begin
				next_rdata[`UFW_OTG_VBUS_PU] = vbusPullUp;
				next_rdata[`UFW_OTG_RX_PD] = rxPowerDown;
				next_rdata[`UFW_OTG_CPUMP] = chargePump;
				next_rdata[`UFW_OTG_VBUS_DIS] = vbusDischarge;
				next_rdata[`UFW_OTG_DP_PU] = dpPullUp;
				next_rdata[`UFW_OTG_DM_PU] = dmPullUp;
				next_rdata[`UFW_OTG_DP_PD] = dpPullDown;
				next_rdata[`UFW_OTG_DM_PD] = dmPullDown;
				next_rdata[`UFW_OTG_VBUS_LVL] = vbusLevel;
				next_rdata[`UFW_OTG_ID] = idLevel;
				next_rdata[`UFW_OTG_VVALID] = vbusValid;
			end
			`UFW_OFS_IEN1: begin
				next_rdata[`UFW_INT_TO] = toEn[0];
				next_rdata[`UFW_INT_ID] = idEn;
			end
			`UFW_OFS_IEN2: next_rdata[`UFW_INT_TO] = toEn[1];
			`UFW_OFS_STAT1: begin
				next_rdata[`UFW_INT_TO] = toFlag[0];
				next_rdata[`UFW_INT_ID] = idFlag;
			end
			`UFW_OFS_STAT2: next_rdata[`UFW_INT_TO] = toFlag[1];
			`UFW_OFS_FRM1: begin
				next_rdata = ufw_frm_word(frmFlag[0], toCnt[0],
					frameLast[0]);
			end
			`UFW_OFS_FRM2: begin
				next_rdata = ufw_frm_word(frmFlag[1], toCnt[1],
					frameLast[1]);
			end
			default: hit = 1'b0;
		endcase
	end

	// ****************************************
	// checks
	// ****************************************
	default clocking cb @(posedge clock);
	endclocking
	default disable iff (rst);

	apb_wait_a: assert property (
		access && !pready |=> pready ##1 !pready)
		else $error("apb answer not one cycle after access");

	otg_write_a: assert property (
		wr && paddr == `UFW_OFS_OTG
		|=> vbusPullUp == $past(pwdata[13])
		&& rxPowerDown == $past(pwdata[12]))
		else $error("otg vbus or receiver bit not written");

	otg_pulls_a: assert property (
		wr && paddr == `UFW_OFS_OTG
		|=> {dpPullUp, dmPullUp, dpPullDown, dmPullDown}
		== $past(pwdata[9:6]))
		else $error("otg pull bits not written");

	timeout_flag_a: assert property (
		expire[0] |=> toFlag[0] ##1 irqDev1 == toEn[0] || idFlag)
		else $error("timeout flag or interrupt missing");

	timeout_count_a: assert property (
		expire[0] && toEn[0] && !marker[0] && toCnt[0] != 3'h7
		|=> toCnt[0] == $past(toCnt[0]) + 3'h1 && frmFlag[0])
		else $error("timeout counter did not advance");

	marker_clear_a: assert property (
		marker[1] && toEn[1] |=> toCnt[1] == 3'h0 && !frmFlag[1])
		else $error("timeout counter not cleared by marker");

	count_read_a: assert property (
		access && !pready && paddr == `UFW_OFS_WDOG2
		|=> prdata[31:14] == 18'h00000 && prdata[13:0] == $past(wdCount[1]))
		else $error("count register read wrong");

	id_edge_a: assert property (
		idEn && $changed(idLevel) |=> idFlag)
		else $error("id edge did not set flag");

	tick_rate_a: assert property (
		tick |=> !tick ##1 !tick)
		else $error("timebase ticks too often");
endmodule
